// *** pkg/pciu_defs.vh ***
// register map, field positions and reset values of the pin change unit
`ifndef PCIU_DEFS_VH
`define PCIU_DEFS_VH
`define PCIU_ADDR_W 12
`define PCIU_OFF_A_FLAG 12'hf05
`define PCIU_OFF_A_FALL 12'hf06
`define PCIU_OFF_A_RISE 12'hf07
`define PCIU_OFF_B_FLAG 12'hf0d
`define PCIU_OFF_B_FALL 12'hf0e
`define PCIU_OFF_B_RISE 12'hf0f
`define PCIU_OFF_C_FLAG 12'hf15
`define PCIU_OFF_C_FALL 12'hf16
`define PCIU_OFF_C_RISE 12'hf17
`define PCIU_OFF_E_FLAG 12'hf22
`define PCIU_OFF_E_FALL 12'hf23
`define PCIU_OFF_E_RISE 12'hf24
`define PCIU_OFF_CTRL 12'hf30
`define PCIU_OFF_STATUS 12'hf31
`define PCIU_OFF_INT_STAT 12'hf32
`define PCIU_OFF_INT_MASK 12'hf33
`define PCIU_E_PIN 3
`define PCIU_E_MASK 8'h08
`define PCIU_CTRL_MASTER_EN 0
`define PCIU_STATUS_SUMMARY 0
`define PCIU_STATUS_E3_OFF 1
`define PCIU_INT_FLAG_A 0
`define PCIU_INT_FLAG_B 1
`define PCIU_INT_FLAG_C 2
`define PCIU_INT_FLAG_E 3
`define PCIU_RST_BYTE 8'h00
`define PCIU_UNMAPPED_DATA 32'h00000000
`endif

// *** src/pciu_top.v ***
// pin change interrupt unit with avalon-mm register slave
// Functional notes
// - every pin of ports a, b, c and port e pin 3 can flag changes.
// - with master enable clear, flags still set and irq_out can rise, but no change_int_out.
// - rising edge detected only while pin's rise enable bit is set.
// - falling edge detected only while pin's fall enable bit is set.
// - both enables set detects either edge, each sets the flag.
// - enabled edge sets pin flag; interrupt raised when master enable set.
// - summary flag is OR of all pin flags, not stored separately.
// - software clears a flag by writing zero; hardware sets it.
// - edge during a flag write leaves that flag set afterwards.
// - with master enable set, a change event wakes the device.
// - flags updated during sleep before first instruction after wake.
// - port e implements only bit 3 in flags and enables.
// - master clear or low voltage programming disables port e pin 3.
//
// The implementer's own choice: register access over Avalon-MM.
`timescale 1ns/1ps
`include "pciu_defs.vh"
module pciu_top #(
  parameter PORT_W = 8
) (
  input wire ref_clk_in,
  input wire rstn_in,
  input wire clk_en_in,
  input wire [PORT_W-1:0] port_a_in,
  input wire [PORT_W-1:0] port_b_in,
  input wire [PORT_W-1:0] port_c_in,
  input wire port_e_pin3_in,
  input wire master_clear_pin_enable_in,
  input wire low_voltage_programming_enable_in,
  input wire [`PCIU_ADDR_W-1:0] avs_address_in,
  input wire avs_read_in,
  input wire avs_write_in,
  input wire [31:0] avs_writedata_in,
  input wire [3:0] avs_byteenable_in,
  output reg [31:0] avs_readdata_out,
  output reg avs_waitrequest_out,
  output reg change_int_out,
  output reg wake_out,
  output reg change_int_summary_flag_out,
  output reg irq_out
);

  // bus answer states
  localparam ST_IDLE = 2'b01;
  localparam ST_DONE = 2'b10;

  reg [1:0] state;
  reg [PORT_W-1:0] sync1_a, sync2_a, prev_a;
  reg [PORT_W-1:0] sync1_b, sync2_b, prev_b;
  reg [PORT_W-1:0] sync1_c, sync2_c, prev_c;
  reg sync1_e, sync2_e, prev_e;
  reg [PORT_W-1:0] port_a_change_flags, port_a_fall_enable;
  reg [PORT_W-1:0] port_a_rise_enable;
  reg [PORT_W-1:0] port_b_change_flags, port_b_fall_enable;
  reg [PORT_W-1:0] port_b_rise_enable;
  reg [PORT_W-1:0] port_c_change_flags, port_c_fall_enable;
  reg [PORT_W-1:0] port_c_rise_enable;
  reg port_e_pin3_flag, port_e_pin3_fall_enable, port_e_pin3_rise_enable;
  reg change_int_master_enable;
  reg [3:0] int_stat;
  reg [3:0] int_mask;

  wire [PORT_W-1:0] edge_a, edge_b, edge_c;
  wire edge_e, e3_off, bus_req, wr_hit, rd_hit, byte0;
  wire [7:0] wbyte;
  reg [PORT_W-1:0] next_flag_a, next_flag_b, next_flag_c;
  reg next_flag_e;
  reg [31:0] next_rdata;
  wire summary;

  assign bus_req = (avs_read_in | avs_write_in) & (state == ST_IDLE);
  assign wr_hit = avs_write_in & (state == ST_IDLE);
  assign rd_hit = avs_read_in & (state == ST_IDLE);
  assign byte0 = avs_byteenable_in[0];
  assign wbyte = avs_writedata_in[7:0];

  assign e3_off = master_clear_pin_enable_in |
                  low_voltage_programming_enable_in;

  assign edge_a = (sync2_a & ~prev_a & port_a_rise_enable) |
                  (~sync2_a & prev_a & port_a_fall_enable);
  assign edge_b = (sync2_b & ~prev_b & port_b_rise_enable) |
                  (~sync2_b & prev_b & port_b_fall_enable);
  assign edge_c = (sync2_c & ~prev_c & port_c_rise_enable) |
                  (~sync2_c & prev_c & port_c_fall_enable);
  assign edge_e = ~e3_off &
                  ((sync2_e & ~prev_e & port_e_pin3_rise_enable) |
                   (~sync2_e & prev_e & port_e_pin3_fall_enable));

  assign summary = (|port_a_change_flags) | (|port_b_change_flags) |
                   (|port_c_change_flags) | port_e_pin3_flag;

  // flag next values: write of zero clears, edge sets and wins
  always @* begin
    next_flag_a = port_a_change_flags;
    next_flag_b = port_b_change_flags;
    next_flag_c = port_c_change_flags;
    next_flag_e = port_e_pin3_flag;
    if (wr_hit && byte0) begin
      case (avs_address_in)
        `PCIU_OFF_A_FLAG: next_flag_a = port_a_change_flags & wbyte;
        `PCIU_OFF_B_FLAG: next_flag_b = port_b_change_flags & wbyte;
        `PCIU_OFF_C_FLAG: next_flag_c = port_c_change_flags & wbyte;
        `PCIU_OFF_E_FLAG:
          next_flag_e = port_e_pin3_flag & wbyte[`PCIU_E_PIN];
        default: next_flag_e = port_e_pin3_flag;
      endcase
    end
    next_flag_a = next_flag_a | edge_a;
    next_flag_b = next_flag_b | edge_b;
    next_flag_c = next_flag_c | edge_c;
    next_flag_e = next_flag_e | edge_e;
  end

  always @* begin
    next_rdata = `PCIU_UNMAPPED_DATA;
    case (avs_address_in)
      `PCIU_OFF_A_FLAG: next_rdata[7:0] = port_a_change_flags;
      `PCIU_OFF_A_FALL: next_rdata[7:0] = port_a_fall_enable;
      `PCIU_OFF_A_RISE: next_rdata[7:0] = port_a_rise_enable;
      `PCIU_OFF_B_FLAG: next_rdata[7:0] = port_b_change_flags;
      `PCIU_OFF_B_FALL: next_rdata[7:0] = port_b_fall_enable;
      `PCIU_OFF_B_RISE: next_rdata[7:0] = port_b_rise_enable;
      `PCIU_OFF_C_FLAG: next_rdata[7:0] = port_c_change_flags;
      `PCIU_OFF_C_FALL: next_rdata[7:0] = port_c_fall_enable;
      `PCIU_OFF_C_RISE: next_rdata[7:0] = port_c_rise_enable;
      `PCIU_OFF_E_FLAG: next_rdata[`PCIU_E_PIN] = port_e_pin3_flag;
      `PCIU_OFF_E_FALL: next_rdata[`PCIU_E_PIN] = port_e_pin3_fall_enable;
      `PCIU_OFF_E_RISE: next_rdata[`PCIU_E_PIN] = port_e_pin3_rise_enable;
      `PCIU_OFF_CTRL:
        next_rdata[`PCIU_CTRL_MASTER_EN] = change_int_master_enable;
      `PCIU_OFF_STATUS: begin
        next_rdata[`PCIU_STATUS_SUMMARY] = summary;
        next_rdata[`PCIU_STATUS_E3_OFF] = e3_off;
      end
      `PCIU_OFF_INT_STAT: next_rdata[3:0] = int_stat;
      `PCIU_OFF_INT_MASK: next_rdata[3:0] = int_mask;
      default: next_rdata = `PCIU_UNMAPPED_DATA;
    endcase
  end

  always @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      state <= ST_IDLE;
      sync1_a <= {PORT_W{1'b0}};
      sync2_a <= {PORT_W{1'b0}};
      prev_a <= {PORT_W{1'b0}};
      sync1_b <= {PORT_W{1'b0}};
      sync2_b <= {PORT_W{1'b0}};
      prev_b <= {PORT_W{1'b0}};
      sync1_c <= {PORT_W{1'b0}};
      sync2_c <= {PORT_W{1'b0}};
      prev_c <= {PORT_W{1'b0}};
      sync1_e <= 1'b0;
      sync2_e <= 1'b0;
      prev_e <= 1'b0;
      port_a_change_flags <= {PORT_W{1'b0}};
      port_a_fall_enable <= {PORT_W{1'b0}};
      port_a_rise_enable <= {PORT_W{1'b0}};
      port_b_change_flags <= {PORT_W{1'b0}};
      port_b_fall_enable <= {PORT_W{1'b0}};
      port_b_rise_enable <= {PORT_W{1'b0}};
      port_c_change_flags <= {PORT_W{1'b0}};
      port_c_fall_enable <= {PORT_W{1'b0}};
      port_c_rise_enable <= {PORT_W{1'b0}};
      port_e_pin3_flag <= 1'b0;
      port_e_pin3_fall_enable <= 1'b0;
      port_e_pin3_rise_enable <= 1'b0;
      change_int_master_enable <= 1'b0;
      int_stat <= 4'h0;
      int_mask <= 4'h0;
      avs_readdata_out <= 32'h00000000;
      avs_waitrequest_out <= 1'b1;
      change_int_out <= 1'b0;
      wake_out <= 1'b0;
      change_int_summary_flag_out <= 1'b0;
      irq_out <= 1'b0;
    end else if (clk_en_in) begin
      sync1_a <= port_a_in;
      sync2_a <= sync1_a;
      prev_a <= sync2_a;
      sync1_b <= port_b_in;
      sync2_b <= sync1_b;
      prev_b <= sync2_b;
      sync1_c <= port_c_in;
      sync2_c <= sync1_c;
      prev_c <= sync2_c;
      sync1_e <= port_e_pin3_in;
      sync2_e <= sync1_e;
      prev_e <= sync2_e;

      port_a_change_flags <= next_flag_a;
      port_b_change_flags <= next_flag_b;
      port_c_change_flags <= next_flag_c;
      port_e_pin3_flag <= next_flag_e;

      // one cycle answer: waitrequest low in the cycle after request
      case (state)
        ST_IDLE: begin
          if (bus_req) begin
            state <= ST_DONE;
            avs_waitrequest_out <= 1'b0;
            avs_readdata_out <= rd_hit ? next_rdata : 32'h00000000;
          end else begin
            avs_waitrequest_out <= 1'b1;
          end
        end
        ST_DONE: begin
          state <= ST_IDLE;
          avs_waitrequest_out <= 1'b1;
        end
        default: begin
          state <= ST_IDLE;
          avs_waitrequest_out <= 1'b1;
        end
      endcase

      if (wr_hit && byte0) begin
        case (avs_address_in)
          `PCIU_OFF_A_FALL: port_a_fall_enable <= wbyte;
          `PCIU_OFF_A_RISE: port_a_rise_enable <= wbyte;
          `PCIU_OFF_B_FALL: port_b_fall_enable <= wbyte;
          `PCIU_OFF_B_RISE: port_b_rise_enable <= wbyte;
          `PCIU_OFF_C_FALL: port_c_fall_enable <= wbyte;
          `PCIU_OFF_C_RISE: port_c_rise_enable <= wbyte;
          `PCIU_OFF_E_FALL: port_e_pin3_fall_enable <= wbyte[`PCIU_E_PIN];
          `PCIU_OFF_E_RISE: port_e_pin3_rise_enable <= wbyte[`PCIU_E_PIN];
          `PCIU_OFF_CTRL:
            change_int_master_enable <= wbyte[`PCIU_CTRL_MASTER_EN];
          `PCIU_OFF_INT_MASK: int_mask <= wbyte[3:0];
          default: int_mask <= int_mask;
        endcase
      end

      // sticky per-port events; a read clears, a new event wins
      if (rd_hit && avs_address_in == `PCIU_OFF_INT_STAT)
        int_stat <= {edge_e, |edge_c, |edge_b, |edge_a};
      else
        int_stat <= int_stat | {edge_e, |edge_c, |edge_b, |edge_a};

      change_int_out <= change_int_master_enable &
                        ((|next_flag_a) | (|next_flag_b) |
                         (|next_flag_c) | next_flag_e);
      wake_out <= change_int_master_enable &
                  ((|edge_a) | (|edge_b) | (|edge_c) | edge_e);
      change_int_summary_flag_out <= (|next_flag_a) | (|next_flag_b) |
                                     (|next_flag_c) | next_flag_e;
      irq_out <= |(int_stat & int_mask);
    end
  end

endmodule // pciu_top

// *** test/pciu_checker_assertions.sv ***
// port checker for the pin change interrupt unit
`timescale 1ns/1ps
module pciu_checker #(parameter PORT_W = 8) (
  input wire logic ref_clk_in,
  input wire logic rstn_in,
  input wire logic [PORT_W-1:0] port_a_in,
  input wire logic [PORT_W-1:0] port_b_in,
  input wire logic [PORT_W-1:0] port_c_in,
  input wire logic port_e_pin3_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic avs_waitrequest_out,
  input wire logic change_int_out,
  input wire logic wake_out,
  input wire logic change_int_summary_flag_out,
  input wire logic irq_out
);
  wire [3*PORT_W:0] pins = {port_e_pin3_in, port_c_in, port_b_in, port_a_in};
  logic [3*PORT_W:0] last_pins;
  logic [2:0] quiet;
  // cycles since a pin last moved; saturates so it never wraps to "recent"
  always @(posedge ref_clk_in or negedge rstn_in)
    if (!rstn_in) begin
      last_pins <= '0;
      quiet <= 3'h7;
    end else begin
      last_pins <= pins;
      quiet <= (pins != last_pins) ? 3'h0 : quiet + {2'h0, quiet != 3'h7};
    end
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (!rstn_in);
  sequence s_taken;
    (avs_read_in || avs_write_in) && avs_waitrequest_out;
  endsequence
  sequence s_answer;
    !avs_waitrequest_out ##1 avs_waitrequest_out;
  endsequence
  bus_answer_a: assert property (s_taken |=> s_answer)
    else $error("bus answer late");
  wait_short_a: assert property (!avs_waitrequest_out |=> avs_waitrequest_out)
    else $error("answer held too long");
  wait_idle_a: assert property (!(avs_read_in || avs_write_in) &&
    avs_waitrequest_out |=> avs_waitrequest_out)
    else $error("answer without request");
  int_needs_flag_a: assert property (change_int_out |->
    change_int_summary_flag_out)
    else $error("interrupt without flag");
  wake_flag_a: assert property (wake_out |->
    ##[0:2] change_int_summary_flag_out)
    else $error("wake without flag");
  flag_rise_a: assert property ($rose(change_int_summary_flag_out) |->
    quiet < 3'h6)
    else $error("flag set without pin change");
  flag_fall_a: assert property ($fell(change_int_summary_flag_out) |->
    $past(avs_write_in) || $past(avs_write_in, 2))
    else $error("flag cleared without write");
  irq_rise_a: assert property ($rose(irq_out) |->
    quiet < 3'h7 || $past(avs_write_in))
    else $error("irq without event");
endmodule // pciu_checker
bind pciu_top pciu_checker #(.PORT_W(PORT_W)) i_pciu_checker (
  .ref_clk_in, .rstn_in, .port_a_in, .port_b_in, .port_c_in,
  .port_e_pin3_in, .avs_read_in, .avs_write_in, .avs_waitrequest_out,
  .change_int_out, .wake_out, .change_int_summary_flag_out, .irq_out);

// *** test/pciu_pins.sv ***
// model of the external signals on the watched port pins
`timescale 1ns/1ps
module pciu_pins (
  input wire logic ref_clk_in,
  output logic [24:0] pins_out
);
  initial pins_out = 25'h0;
  // a pin moves lag cycles after the call, always just past an edge
  task automatic flip(input int idx, input int lag);
    repeat (lag) @(posedge ref_clk_in);
    pins_out[idx] <= ~pins_out[idx];
  endtask
endmodule // pciu_pins

// *** test/tb_pciu_top.sv ***
// self-checking bench for the pin change interrupt unit
`timescale 1ns/1ps
module tb_pciu_top;
  logic ref_clk_in = 0, rstn_in = 0, mclr = 0, low_voltage_programming_enable = 0;
  logic req_rd = 0, req_wr = 0, woke = 0;
  logic [3:0] be = 4'hf;
  logic [11:0] adr = 12'h000;
  logic [31:0] wdat = 32'h0, got;
  wire [24:0] pins;
  wire [31:0] rdata;
  wire wreq, cint, wake, summ, irq;
  int failures = 0, checks = 0, k;
  logic [11:0] en_adr [8] = '{12'hf06, 12'hf07, 12'hf0e, 12'hf0f,
    12'hf16, 12'hf17, 12'hf23, 12'hf24};
  logic [7:0] en_val [8] = '{8'h02, 8'h01, 8'h80, 8'h80, 8'h00, 8'hff,
    8'hff, 8'hff};
  always #20 ref_clk_in = ~ref_clk_in;
  always @(posedge ref_clk_in) if (wake) woke <= 1;
  pciu_pins i_pciu_pins (.ref_clk_in, .pins_out(pins));
  pciu_top i_pciu_top (.ref_clk_in, .rstn_in, .clk_en_in(1'b1),
    .port_a_in(pins[7:0]), .port_b_in(pins[15:8]),
    .port_c_in(pins[23:16]), .port_e_pin3_in(pins[24]),
    .master_clear_pin_enable_in(mclr),
    .low_voltage_programming_enable_in(low_voltage_programming_enable), .avs_address_in(adr),
    .avs_read_in(req_rd), .avs_write_in(req_wr), .avs_writedata_in(wdat),
    .avs_byteenable_in(be), .avs_readdata_out(rdata),
    .avs_waitrequest_out(wreq), .change_int_out(cint), .wake_out(wake),
    .change_int_summary_flag_out(summ), .irq_out(irq));
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk_in);
  endtask
  task automatic chk(input string n, input logic [31:0] s, e);
    checks++;
    if (s !== e) begin
      failures++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic stop_test();
    if (failures == 0 && checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic bus(input logic w, input logic [11:0] a, input logic [7:0] d);
    int n;
    adr <= a;
    wdat <= {24'h0, d};
    req_wr <= w;
    req_rd <= !w;
    for (n = 0; n < 9; n++) begin
      tick(1);
      if (wreq === 1'b0) break;
    end
    got = rdata;
    req_wr <= 0;
    req_rd <= 0;
    // let the release stand one edge before any next request
    tick(1);
    if (n == 9) begin
      failures++;
      stop_test();
    end
  endtask
  task automatic rd(input logic [11:0] a, input logic [7:0] e);
    bus(0, a, 8'h00);
    chk($sformatf("reg %h", a), got, {24'h0, e});
  endtask
  // clear only the flags seen, so a fresh edge survives
  task automatic clr(input logic [11:0] a);
    bus(0, a, 8'h00);
    bus(1, a, got[7:0] ^ 8'hff);
  endtask
  task automatic pin(input int i);
    i_pciu_pins.flip(i, i % 3);
    tick(6);
  endtask
  initial begin
    tick(20);
    rstn_in <= 1;
    for (k = 'hf05; k <= 'hf33; k++) rd(k[11:0], 8'h00);
    for (k = 0; k < 8; k++) begin
      bus(1, en_adr[k], en_val[k]);
      rd(en_adr[k], en_val[k] & (k > 5 ? 8'h08 : 8'hff));
    end
    be <= 4'h0;
    bus(1, 12'hf06, 8'hff);
    be <= 4'hf;
    rd(12'hf06, 8'h02);
    pin(0);
    rd(12'hf05, 8'h01);
    chk("int", cint, 0);
    pin(1);
    rd(12'hf05, 8'h01);
    pin(1);
    rd(12'hf05, 8'h03);
    pin(0);
    rd(12'hf05, 8'h03);
    chk("wake", woke, 0);
    pin(15);
    clr(12'hf0d);
    pin(15);
    rd(12'hf0d, 8'h80);
    clr(12'hf0d);
    chk("summary", summ, 1);
    clr(12'hf05);
    rd(12'hf05, 8'h00);
    chk("summary", summ, 0);
    // edge lands in the cycle the clearing write is taken
    i_pciu_pins.flip(15, 0);
    tick(2);
    bus(1, 12'hf0d, 8'h00);
    rd(12'hf0d, 8'h80);
    clr(12'hf0d);
    bus(0, 12'hf32, 8'h00);
    bus(1, 12'hf33, 8'h01);
    bus(1, 12'hf30, 8'h01);
    pin(16);
    chk("int", cint, 1);
    chk("wake", woke, 1);
    chk("irq", irq, 0);
    rd(12'hf15, 8'h01);
    rd(12'hf32, 8'h04);
    rd(12'hf32, 8'h00);
    pin(0);
    chk("irq", irq, 1);
    rd(12'hf32, 8'h01);
    tick(3);
    chk("irq", irq, 0);
    for (k = 0; k < 2; k++) begin
      mclr <= (k == 0);
      low_voltage_programming_enable <= (k == 1);
      pin(24);
      rd(12'hf22, 8'h00);
      rd(12'hf31, 8'h03);
    end
    mclr <= 0;
    low_voltage_programming_enable <= 0;
    pin(24);
    rd(12'hf22, 8'h08);
    rstn_in <= 0;
    tick(3);
    rstn_in <= 1;
    rd(12'hf05, 8'h00);
    stop_test();
  end
endmodule // tb_pciu_top
